// >>> fdm_ctrl.sv
// apb-mapped flash data memory control: address, data, control and bit-set registers
//
// Behaviour
// - the last address register value selects the byte that a read fetches
// - bit-set of the read trigger starts a read; data lands in data register
// - data register holds its value until a new read or a software write
// - the read access is stalled for the read cycle, then completes
// - only a bit-set access launches a read; other writes cannot
// - erase works on whole rows, programming on single bytes
// - 64 bytes as eight rows of eight, row boundary every eighth address
// - erase or program starts only after the exact unlock sequence of consecutive enable and trigger bit-sets
// - erase-select is cleared unless write enable is bit-set in the next access
// - write enable is cleared unless write trigger is bit-set in the next access
// - the trigger access is stalled while the erase runs
// - erase-select takes a bit-set or a control register write; enable and trigger need consecutive bit-sets
// - row erase uses address bits 5 to 3, ignoring bits 2 to 0
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "fdm_regs.svh"
module fdm_ctrl (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic busy_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state and registers

  fdm_pkg::fdm_state_t state;
  logic [`FDM_ADDR_W-1:0] nvm_address_reg;
  logic [`FDM_DATA_W-1:0] nvm_data_reg;
  logic rd_bit;
  logic wr_bit;
  logic write_enable_bit;
  logic erase_bit;
  logic erase_armed;
  logic [`FDM_CNT_W-1:0] cnt;
  fdm_pkg::fdm_cmd_t cmd;
  logic [`FDM_DATA_W-1:0] array_rd;

  ////////////////////////////////////////////////////////////////////////////////
  // access decode

  function automatic logic fdm_hit(input logic [11:0] a, input logic [11:0] ofs);
    fdm_hit = (a == ofs);
  endfunction : fdm_hit

  function automatic logic fdm_bit_is(input logic [`FDM_BIT_IDX_W-1:0] idx, input logic [`FDM_BIT_IDX_W-1:0] pos);
    fdm_bit_is = (idx == pos);
  endfunction : fdm_bit_is

  logic take;
  logic hit_addr;
  logic hit_data;
  logic hit_ctrl;
  logic hit_bset;
  logic mapped;
  logic wr_addr;
  logic wr_data;
  logic wr_ctrl;
  logic bset;
  logic [`FDM_BIT_IDX_W-1:0] bidx;
  logic bs_rd;
  logic bs_wr;
  logic bs_write_enable_bit;
  logic bs_erase;
  logic sets_erase;
  logic start_read;
  logic start_nvm;
  logic done;
  logic [3:0] ctrl_view;

  assign take = psel_in && penable_in && !pready_out && (state == fdm_pkg::FDM_IDLE);
  assign hit_addr = fdm_hit(paddr_in, `FDM_ADDR_OFS);
  assign hit_data = fdm_hit(paddr_in, `FDM_DATA_OFS);
  assign hit_ctrl = fdm_hit(paddr_in, `FDM_CTRL_OFS);
  assign hit_bset = fdm_hit(paddr_in, `FDM_BSET_OFS);
  assign mapped = hit_addr || hit_data || hit_ctrl || hit_bset;

  assign wr_addr = take && pwrite_in && hit_addr;
  assign wr_data = take && pwrite_in && hit_data;
  assign wr_ctrl = take && pwrite_in && hit_ctrl;
  assign bset = take && pwrite_in && hit_bset;
  assign bidx = pwdata_in[`FDM_BIT_IDX_W-1:0];

  // only the bit-set register can raise the trigger and enable bits
  assign bs_rd = bset && fdm_bit_is(bidx, 3'(`FDM_BIT_RD));
  assign bs_wr = bset && fdm_bit_is(bidx, 3'(`FDM_BIT_WR));
  assign bs_write_enable_bit = bset && fdm_bit_is(bidx, 3'(`FDM_BIT_WRITE_ENABLE_BIT));
  assign bs_erase = bset && fdm_bit_is(bidx, 3'(`FDM_BIT_ERASE));

  // erase-select may be raised by an ordinary write as well
  assign sets_erase = bs_erase || (wr_ctrl && pwdata_in[`FDM_BIT_ERASE]);

  assign start_read = bs_rd;
  assign start_nvm = bs_wr && write_enable_bit;
  assign done = (state != fdm_pkg::FDM_IDLE) && (cnt == '0);

  assign ctrl_view = {erase_bit, write_enable_bit, wr_bit, rd_bit};

  ////////////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= fdm_pkg::FDM_IDLE;
      cnt <= '0;
    end else if (ce_in) begin
      case (state)
        fdm_pkg::FDM_IDLE: begin
          if (start_read) begin
            state <= fdm_pkg::FDM_READ;
            cnt <= 16'(`FDM_READ_CYCLES - 1);
          end else if (start_nvm && erase_bit) begin
            state <= fdm_pkg::FDM_ERASE;
            cnt <= 16'(`FDM_ERASE_CYCLES - 1);
          end else if (start_nvm) begin
            state <= fdm_pkg::FDM_PROG;
            cnt <= 16'(`FDM_PROG_CYCLES - 1);
          end
        end
        fdm_pkg::FDM_READ, fdm_pkg::FDM_ERASE, fdm_pkg::FDM_PROG: begin
          if (done) begin
            state <= fdm_pkg::FDM_IDLE;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        default: begin
          state <= fdm_pkg::FDM_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      busy_out <= 1'b0;
    end else if (ce_in) begin
      if (start_read || start_nvm) begin
        busy_out <= 1'b1;
      end else if (done) begin
        busy_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address register

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      nvm_address_reg <= `FDM_ADDR_RST;
    end else if (ce_in && wr_addr) begin
      nvm_address_reg <= pwdata_in[`FDM_ADDR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data register

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      nvm_data_reg <= `FDM_DATA_RST;
    end else if (ce_in) begin
      if ((state == fdm_pkg::FDM_READ) && done) begin
        nvm_data_reg <= array_rd;
      end else if (wr_data) begin
        nvm_data_reg <= pwdata_in[`FDM_DATA_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read trigger

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_bit <= 1'b0;
    end else if (ce_in) begin
      if (start_read) begin
        rd_bit <= 1'b1;
      end else if ((state == fdm_pkg::FDM_READ) && done) begin
        rd_bit <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write trigger

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_bit <= 1'b0;
    end else if (ce_in) begin
      if (start_nvm) begin
        wr_bit <= 1'b1;
      end else if (done && (state != fdm_pkg::FDM_READ)) begin
        wr_bit <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write enable: survives only into a bit-set of the write trigger

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_bit <= 1'b0;
    end else if (ce_in) begin
      if (bs_write_enable_bit) begin
        write_enable_bit <= 1'b1;
      end else if (take && write_enable_bit && !bs_wr) begin
        write_enable_bit <= 1'b0;
      end else if (done && (state != fdm_pkg::FDM_READ)) begin
        write_enable_bit <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // erase select: survives only into a bit-set of write enable

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      erase_bit <= 1'b0;
      erase_armed <= 1'b0;
    end else if (ce_in) begin
      if (take) begin
        erase_armed <= sets_erase;
      end
      if (sets_erase) begin
        erase_bit <= 1'b1;
      end else if (wr_ctrl) begin
        erase_bit <= 1'b0;
      end else if (take && erase_armed && !bs_write_enable_bit) begin
        erase_bit <= 1'b0;
      end else if (done && (state == fdm_pkg::FDM_ERASE)) begin
        erase_bit <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array command, issued as the cycle ends

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else if (ce_in) begin
      cmd.erase <= done && (state == fdm_pkg::FDM_ERASE);
      cmd.prog <= done && (state == fdm_pkg::FDM_PROG);
      cmd.addr <= nvm_address_reg;
      cmd.data <= nvm_data_reg;
    end
  end

  fdm_array u_array (
    .clk_sys_in(clk_sys_in),
    .ce_in(ce_in),
    .cmd_in(cmd),
    .rd_addr_in(nvm_address_reg),
    .rd_data_out(array_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // apb answer
  // trigger accesses are answered when their cycle ends

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else if (ce_in) begin
      if (pready_out) begin
        pready_out <= 1'b0;
        pslverr_out <= 1'b0;
      end else if (take && !start_read && !start_nvm) begin
        pready_out <= 1'b1;
        pslverr_out <= !mapped;
      end else if (done) begin
        pready_out <= 1'b1;
        pslverr_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb read data

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out <= '0;
    end else if (ce_in) begin
      if (take && !pwrite_in) begin
        if (hit_addr) begin
          prdata_out <= {26'h0, nvm_address_reg};
        end else if (hit_data) begin
          prdata_out <= {24'h0, nvm_data_reg};
        end else if (hit_ctrl) begin
          prdata_out <= {28'h0, ctrl_view};
        end else begin
          prdata_out <= '0;
        end
      end else if (pready_out) begin
        prdata_out <= '0;
      end
    end
  end

endmodule : fdm_ctrl

// >>> fdm_regs.svh
// register offsets, field positions, reset values and timing counts of the flash data memory control
`ifndef FDM_REGS_SVH
`define FDM_REGS_SVH

// apb byte offsets
`define FDM_ADDR_OFS 12'h000
`define FDM_DATA_OFS 12'h004
`define FDM_CTRL_OFS 12'h008
`define FDM_BSET_OFS 12'h00c

// control register bit positions, also the bit numbers of a bit-set access
`define FDM_BIT_RD 0
`define FDM_BIT_WR 1
`define FDM_BIT_WRITE_ENABLE_BIT 2
`define FDM_BIT_ERASE 3
`define FDM_BIT_IDX_W 3

// array geometry
`define FDM_ADDR_W 6
`define FDM_DATA_W 8
`define FDM_ROW_W 3
`define FDM_DEPTH 64
`define FDM_ROWS 8
`define FDM_ROW_BYTES 8
`define FDM_ERASED 8'hff

// reset values
`define FDM_ADDR_RST 6'h00
`define FDM_DATA_RST 8'h00
`define FDM_CNT_W 16

// timing
`define FDM_CLK_MHZ 50
`define FDM_READ_TIME_NS 40
`define FDM_ERASE_TIME_NS 2000
`define FDM_PROG_TIME_NS 1000
`define FDM_READ_CYCLES ((`FDM_READ_TIME_NS * `FDM_CLK_MHZ + 999) / 1000)
`define FDM_ERASE_CYCLES ((`FDM_ERASE_TIME_NS * `FDM_CLK_MHZ + 999) / 1000)
`define FDM_PROG_CYCLES ((`FDM_PROG_TIME_NS * `FDM_CLK_MHZ + 999) / 1000)

`endif

// >>> fdm_pkg.sv
// types shared by the flash data memory control and its array
`include "fdm_regs.svh"
package fdm_pkg;

  typedef enum logic [1:0] {
    FDM_IDLE = 2'b00,
    FDM_READ = 2'b01,
    FDM_ERASE = 2'b10,
    FDM_PROG = 2'b11
  } fdm_state_t;

  typedef struct packed {
    logic erase;
    logic prog;
    logic [`FDM_ADDR_W-1:0] addr;
    logic [`FDM_DATA_W-1:0] data;
  } fdm_cmd_t;

  function automatic logic [`FDM_ROW_W-1:0] fdm_row(input logic [`FDM_ADDR_W-1:0] a);
    fdm_row = a[`FDM_ADDR_W-1:`FDM_ADDR_W-`FDM_ROW_W];
  endfunction : fdm_row

endpackage : fdm_pkg

// >>> fdm_array.sv
// 64-byte flash data array with row erase and byte program
`timescale 1ns/1ps
`include "fdm_regs.svh"
module fdm_array (
  input wire logic clk_sys_in,
  input wire logic ce_in,
  input wire fdm_pkg::fdm_cmd_t cmd_in,
  input wire logic [`FDM_ADDR_W-1:0] rd_addr_in,
  output logic [`FDM_DATA_W-1:0] rd_data_out
);

  logic [`FDM_DATA_W-1:0] mem [0:`FDM_DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////////
  // one row of eight bytes per outer step
  genvar r, b;
  generate
    for (r = 0; r < `FDM_ROWS; r = r + 1) begin : g_row
      for (b = 0; b < `FDM_ROW_BYTES; b = b + 1) begin : g_byte
        always_ff @(posedge clk_sys_in) begin
          if (ce_in) begin
            if (cmd_in.erase && (fdm_pkg::fdm_row(cmd_in.addr) == 3'(r))) begin
              mem[r * `FDM_ROW_BYTES + b] <= `FDM_ERASED;
            end else if (cmd_in.prog && (cmd_in.addr == 6'(r * `FDM_ROW_BYTES + b))) begin
              mem[r * `FDM_ROW_BYTES + b] <= mem[r * `FDM_ROW_BYTES + b] & cmd_in.data;
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // immediate read
  assign rd_data_out = mem[rd_addr_in];

endmodule : fdm_array

// >>> fdm_ctrl_props.sv
// concurrent checks on the apb side of the flash data memory control
`timescale 1ns/1ps
`include "fdm_regs.svh"
module fdm_ctrl_props (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic busy_out
);
  localparam int ERASE_MAX = `FDM_ERASE_CYCLES;
  logic setup;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in || !ce_in);
  assign setup = psel_in && !penable_in && !busy_out;
  ////////////////////////////////////////////////////////////////
  rdy_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");
  busy_stall_a: assert property (busy_out |-> !pready_out)
    else $error("pready while busy");
  rd_launch_a: assert property (setup && pwrite_in && paddr_in == `FDM_BSET_OFS && pwdata_in[2:0] == 3'h0
    |=> ##1 busy_out [*2] ##1 (pready_out && !busy_out)) else $error("read trigger timing wrong");
  ctl_noread_a: assert property (setup && pwrite_in && paddr_in == `FDM_CTRL_OFS
    |=> ##1 (pready_out && !busy_out)) else $error("control write stalled");
  addr_wait_a: assert property (setup && paddr_in == `FDM_ADDR_OFS |=> !pready_out ##1 pready_out)
    else $error("address access not one wait state");
  bad_addr_a: assert property (setup && paddr_in > `FDM_BSET_OFS
    |=> ##1 (pready_out && pslverr_out && prdata_out == 32'h0)) else $error("unmapped access not refused");
  busy_bound_a: assert property ($rose(busy_out) |-> ##[1:ERASE_MAX] !busy_out)
    else $error("busy too long");
  done_ack_a: assert property ($fell(busy_out) |-> pready_out)
    else $error("cycle end without pready");
  up_zero_a: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  rd_quiet_a: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer cycle");
endmodule : fdm_ctrl_props

bind fdm_ctrl fdm_ctrl_props i_fdm_ctrl_props (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in),
  .ce_in(ce_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .busy_out(busy_out));

// >>> fdm_core_model.sv
// core-side apb master model issuing register and bit-set accesses
`timescale 1ns/1ps
module fdm_core_model (
  input wire logic clk_sys_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out
);
  logic [31:0] rdata;
  logic err;
  int cyc;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h0;
    pwdata_out = 32'h0;
  end
  // one access; cyc counts access-phase edges up to pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc = 0;
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      cyc++;
    end while (pready_in !== 1'b1 && cyc < 400);
    rdata = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~d;
    @(posedge clk_sys_in);
  endtask : xfer
endmodule : fdm_core_model

// >>> fdm_ctrl_test.sv
// self-checking bench for the flash data memory control
`timescale 1ns/1ps
`include "fdm_regs.svh"
module fdm_ctrl_test;
  typedef struct packed {logic [11:0] a; logic [31:0] wd; logic [31:0] exp; logic err;} fdm_row_t;
  logic clk_sys_in, rstn_in, psel, penable, pwrite, pready, pslverr, busy;
  logic ce = 1'b1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int fails = 0;
  int n_tests = 0;
  fdm_row_t rows [5] = '{'{12'h000, 32'hffff_ffea, 32'h2a, 1'b0}, '{12'h004, 32'h15a, 32'h5a, 1'b0},
    '{12'h008, 32'h7, 32'h0, 1'b0}, '{12'h00c, 32'h5, 32'h0, 1'b0}, '{12'h010, 32'haa, 32'h0, 1'b1}};
  fdm_ctrl i_fdm_ctrl (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .busy_out(busy));
  fdm_core_model i_fdm_core_model (.clk_sys_in(clk_sys_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata));
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_fdm_core_model.xfer(w, a, d);
    if (i_fdm_core_model.cyc >= 400) begin
      fails++;
      end_sim();
    end
  endtask : acc
  task automatic setb(input logic [31:0] b, input logic [31:0] n);
    acc(1'b1, `FDM_BSET_OFS, b);
    chk("stall", i_fdm_core_model.cyc, n);
  endtask : setb
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    acc(1'b1, `FDM_ADDR_OFS, {20'h0, a});
    setb(0, `FDM_READ_CYCLES + 2);
    acc(1'b0, `FDM_DATA_OFS, 32'h0);
    chk("byte", i_fdm_core_model.rdata, {24'h0, e});
  endtask : rd
  task automatic rdreg(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk("reg", i_fdm_core_model.rdata, e);
  endtask : rdreg
  task automatic er(input logic [11:0] a);
    acc(1'b1, `FDM_ADDR_OFS, {20'h0, a});
    setb(3, 2);
    setb(2, 2);
    setb(1, `FDM_ERASE_CYCLES + 2);
  endtask : er
  task automatic pg(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, `FDM_ADDR_OFS, {20'h0, a});
    acc(1'b1, `FDM_DATA_OFS, d);
    setb(2, 2);
    setb(1, `FDM_PROG_CYCLES + 2);
  endtask : pg
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    rstn_in = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    foreach (rows[i]) begin
      acc(1'b1, rows[i].a, rows[i].wd);
      chk("werr", {31'h0, i_fdm_core_model.err}, {31'h0, rows[i].err});
      rdreg(rows[i].a, rows[i].exp);
      chk("rerr", {31'h0, i_fdm_core_model.err}, {31'h0, rows[i].err});
    end
    er(12'h018);
    pg(12'h018, 32'h3c);
    er(12'h013);
    pg(12'h011, 32'ha5);
    rdreg(`FDM_CTRL_OFS, 32'h0);
    rd(12'h010, 8'hff);
    rd(12'h017, 8'hff);
    rd(12'h012, 8'hff);
    rd(12'h011, 8'ha5);
    rd(12'h018, 8'h3c);
    acc(1'b1, `FDM_ADDR_OFS, 32'h10);
    acc(1'b1, `FDM_CTRL_OFS, 32'h1);
    chk("stall", i_fdm_core_model.cyc, 2);
    rdreg(`FDM_DATA_OFS, 32'h3c);
    acc(1'b1, `FDM_DATA_OFS, 32'h77);
    rdreg(`FDM_DATA_OFS, 32'h77);
    setb(3, 2);
    rdreg(`FDM_CTRL_OFS, 32'h8);
    rdreg(`FDM_CTRL_OFS, 32'h0);
    acc(1'b1, `FDM_ADDR_OFS, 32'h18);
    acc(1'b1, `FDM_DATA_OFS, 32'h0);
    setb(2, 2);
    rdreg(`FDM_CTRL_OFS, 32'h4);
    setb(1, 2);
    rdreg(`FDM_CTRL_OFS, 32'h0);
    rd(12'h018, 8'h3c);
    acc(1'b1, `FDM_CTRL_OFS, 32'h8);
    setb(2, 2);
    setb(1, `FDM_ERASE_CYCLES + 2);
    rd(12'h018, 8'hff);
    rd(12'h01f, 8'hff);
    pg(12'h018, 32'h3c);
    rd(12'h018, 8'h3c);
    fork
      acc(1'b1, `FDM_DATA_OFS, 32'h33);
      begin
        @(posedge clk_sys_in);
        ce <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        ce <= 1'b1;
      end
    join
    chk("hold", i_fdm_core_model.cyc, 5);
    rdreg(`FDM_DATA_OFS, 32'h33);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rdreg(`FDM_ADDR_OFS, {26'h0, `FDM_ADDR_RST});
    rdreg(`FDM_DATA_OFS, {24'h0, `FDM_DATA_RST});
    rdreg(`FDM_CTRL_OFS, 32'h0);
    end_sim();
  end
endmodule : fdm_ctrl_test
